//--- rtl/bcs_pkg.sv
// Constants, types and register layout for the bus compatibility and low-power block.
// Assumes a single 40 MHz system clock and an 8-bit processor I/O space.
//
// Behaviour
// - Fetch strobe enable resets to one
// - Enabled: strobe on fetch and acknowledge cycles
// - Enabled: return opcode fetched once, three clocks
// - Disabled: no fetch strobe, return opcode refetched
// - Refetch: gap, strobed first byte, gap, second byte, stack
// - One-shot bit reads one, resets one
// - Writing one-shot zero forces next fetch strobe
// - Forced strobe lapses by itself after once
// - I/O timing bit resets one, alternative timing
// - Idle with release bit grants bus
// - Idle grant ends: clock output stops
// - Idle grant answer eight clocks later
// - Standby wake with flag set: service interrupt
// - Standby interrupt wake, flag clear: resume after sleep
// - Interrupt wake line drops early: stay in standby
// - Standby restart waits 64 or 131072 clocks
// - Standby grant waits 64 or 131072 clocks
`default_nettype none

package bcs_pkg;
  localparam logic [7:0] OMC_ADDR = 8'h3e;
  localparam int OMC_FSE_BIT = 7;
  localparam int OMC_ONESHOT_BIT = 6;
  localparam int OMC_IOC_BIT = 5;
  localparam logic OMC_FSE_RESET = 1'h1;
  localparam logic OMC_IOC_RESET = 1'h1;
  localparam logic [7:0] OPC_FIRST = 8'hed;
  localparam logic [7:0] OPC_SECOND = 8'h4d;
  localparam logic [1:0] REFETCH_GAP_CYC = 2'h3;
  localparam logic [17:0] RUN_BREQ_CYC = 18'h00001;
  localparam logic [17:0] IDLE_EXTRA_CYC = 18'h00008;
  localparam logic [17:0] QUICK_RECOVERY_CYC = 18'h00040;
  localparam int SLOW_RECOVERY_DEFAULT = 131072;

  typedef enum logic [2:0] {
    CY_OPCODE, CY_INTACK, CY_NMIACK, CY_MEMRD, CY_MEMWR, CY_IORD, CY_IOWR
  } bcs_cyc_t;
  typedef enum logic [2:0] {BT_FREE, BT_T1, BT_T2, BT_T3, BT_TI} bcs_tst_t;
  typedef enum logic [2:0] {SQ_NONE, SQ_GAP3, SQ_ED, SQ_GAP1, SQ_4D, SQ_SP0, SQ_SP1} bcs_seq_t;
  typedef enum logic [1:0] {G_OFF, G_WAIT, G_ON} bcs_grant_t;
  typedef enum logic [1:0] {P_RUN, P_IDLE, P_STBY, P_WAKE} bcs_pwr_t;
endpackage

`default_nettype wire

//--- rtl/bcs_ctrl.sv
// Bus cycle strobes, return-opcode refetch, mode register and low-power exit/bus grant.
// Assumes the core issues one bus cycle at a time and waits on cyc_ready.
`default_nettype none

module bcs_ctrl
  import bcs_pkg::*;
#(
  parameter int SLOW_RECOVERY_CYC = SLOW_RECOVERY_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic cyc_start,
  input wire bcs_cyc_t cyc_type,
  input wire logic [19:0] cyc_addr,
  input wire logic [7:0] cyc_wdata,
  input wire logic [19:0] stack_pointer,
  output logic cyc_ready,
  output logic cyc_done,
  output logic [7:0] cyc_rdata,
  output logic [19:0] addr_out,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] data_in,
  output logic bus_oe,
  output logic memory_request_strobe_n,
  output logic io_request_strobe_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic fetch_cycle_strobe_n,
  output logic status_line,
  input wire logic sleep_req,
  input wire logic sleep_standby,
  input wire logic low_power_bus_release_bit,
  input wire logic quick_recovery_select,
  input wire logic interrupt_enable_flag,
  input wire logic [2:0] ext_int_enable,
  input wire logic nmi_n,
  input wire logic [2:0] ext_int_n,
  input wire logic bus_request_n,
  output logic bus_ack_n,
  output logic system_clock_output_en,
  output logic wake_service,
  output logic wake_resume
);
  logic fetch_strobe_enable;
  logic io_timing_compat;
  logic force_pend;
  logic [12:0] sync1;
  logic [12:0] sync2;
  bcs_tst_t tst;
  bcs_seq_t seq;
  bcs_cyc_t ctype;
  logic cur_m1;
  logic cur_st_low;
  logic [1:0] idle_cnt;
  logic prev_ed;
  logic [19:0] ed_addr;
  logic [19:0] sp_lat;
  bcs_grant_t gst;
  logic [17:0] gcnt;
  bcs_pwr_t pmode;
  logic [17:0] wcnt;
  logic wnmi;
  logic nmi_low;
  logic breq;
  logic int_pending;
  logic [7:0] din;
  logic core_start;
  logic omc_wr;
  logic bus_quiet;
  logic incyc;
  logic is_mem;
  logic is_read;
  logic io_act;
  logic return_from_interrupt_seen;
  logic [17:0] grant_target;

  function automatic logic [17:0] recovery_cycles(input logic quick);
    return quick ? QUICK_RECOVERY_CYC : SLOW_RECOVERY_CYC[17:0];
  endfunction

  // Pin inputs: two stages before use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 13'h1fff;
      sync2 <= 13'h1fff;
    end else begin
      sync1 <= {bus_request_n, nmi_n, ext_int_n, data_in};
      sync2 <= sync1;
    end
  end

  assign din = sync2[7:0];
  assign int_pending = |(~sync2[10:8] & ext_int_enable);
  assign nmi_low = !sync2[11];
  assign breq = !sync2[12];

  assign omc_wr = io_wr && (io_addr == OMC_ADDR);
  assign bus_quiet = (tst == BT_FREE) && (seq == SQ_NONE);
  assign cyc_ready = bus_quiet && (pmode == P_RUN) && (gst == G_OFF) && !breq;
  assign core_start = cyc_start && cyc_ready;

  // Mode register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_strobe_enable <= OMC_FSE_RESET;
      io_timing_compat <= OMC_IOC_RESET;
    end else if (omc_wr) begin
      fetch_strobe_enable <= io_wdata[OMC_FSE_BIT];
      io_timing_compat <= io_wdata[OMC_IOC_BIT];
    end
  end

  // One-shot request; a new write wins over the lapse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      force_pend <= 1'b0;
    end else if (omc_wr && !io_wdata[OMC_ONESHOT_BIT]) begin
      force_pend <= 1'b1;
    end else if (core_start && cyc_type == CY_OPCODE) begin
      force_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
    end else if (io_rd && io_addr == OMC_ADDR) begin
      io_rdata <= 8'h00;
      io_rdata[OMC_FSE_BIT] <= fetch_strobe_enable;
      io_rdata[OMC_ONESHOT_BIT] <= 1'b1;
      io_rdata[OMC_IOC_BIT] <= io_timing_compat;
    end
  end

  assign return_from_interrupt_seen = (ctype == CY_OPCODE) && (seq == SQ_NONE) && prev_ed && (din == OPC_SECOND);

  // Bus cycle engine and return-opcode refetch sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tst <= BT_FREE;
      seq <= SQ_NONE;
      ctype <= CY_MEMRD;
      cur_m1 <= 1'b0;
      cur_st_low <= 1'b0;
      idle_cnt <= 2'h0;
      prev_ed <= 1'b0;
      ed_addr <= 20'h00000;
      sp_lat <= 20'h00000;
      addr_out <= 20'h00000;
      data_out <= 8'h00;
      cyc_done <= 1'b0;
      cyc_rdata <= 8'h00;
    end else begin
      cyc_done <= 1'b0;
      unique case (tst)
        BT_FREE: begin
          if (core_start) begin
            tst <= BT_T1;
            ctype <= cyc_type;
            addr_out <= cyc_addr;
            data_out <= cyc_wdata;
            cur_m1 <= (cyc_type inside {CY_OPCODE, CY_INTACK, CY_NMIACK})
                      && (fetch_strobe_enable || force_pend);
            cur_st_low <= (cyc_type == CY_OPCODE);
            sp_lat <= stack_pointer;
          end
        end
        BT_T1: tst <= BT_T2;
        BT_T2: tst <= BT_T3;
        BT_T3: begin
          cyc_done <= 1'b1;
          cyc_rdata <= din;
          tst <= BT_FREE;
          if (ctype == CY_OPCODE && seq == SQ_NONE) begin
            prev_ed <= (din == OPC_FIRST);
            if (din == OPC_FIRST) begin
              ed_addr <= addr_out;
            end
          end
          if (return_from_interrupt_seen && !fetch_strobe_enable) begin
            seq <= SQ_GAP3;
            tst <= BT_TI;
            idle_cnt <= REFETCH_GAP_CYC - 2'h1;
            prev_ed <= 1'b0;
          end else begin
            unique case (seq)
              SQ_ED: begin
                seq <= SQ_GAP1;
                tst <= BT_TI;
                idle_cnt <= 2'h0;
              end
              SQ_4D: begin
                seq <= SQ_SP0;
                tst <= BT_T1;
                ctype <= CY_MEMRD;
                addr_out <= sp_lat;
                cur_m1 <= 1'b0;
              end
              SQ_SP0: begin
                seq <= SQ_SP1;
                tst <= BT_T1;
                addr_out <= sp_lat + 20'h00001;
              end
              SQ_SP1: seq <= SQ_NONE;
              default: ;
            endcase
          end
        end
        BT_TI: begin
          if (idle_cnt != 2'h0) begin
            idle_cnt <= idle_cnt - 2'h1;
          end else begin
            tst <= BT_T1;
            ctype <= CY_OPCODE;
            cur_st_low <= 1'b0;
            if (seq == SQ_GAP3) begin
              seq <= SQ_ED;
              addr_out <= ed_addr;
              cur_m1 <= 1'b1;
            end else begin
              seq <= SQ_4D;
              addr_out <= ed_addr + 20'h00001;
              cur_m1 <= 1'b0;
            end
          end
        end
        default: tst <= BT_FREE;
      endcase
    end
  end

  // Strobe decode; three clocks per cycle, no refetch when enabled
  assign incyc = tst inside {BT_T1, BT_T2, BT_T3};
  assign is_mem = ctype inside {CY_OPCODE, CY_NMIACK, CY_MEMRD, CY_MEMWR};
  assign is_read = ctype inside {CY_OPCODE, CY_NMIACK, CY_MEMRD};
  assign io_act = incyc && (ctype inside {CY_IORD, CY_IOWR})
                  && (io_timing_compat || tst != BT_T1);
  assign memory_request_strobe_n = !(incyc && is_mem);
  assign io_request_strobe_n = !(io_act || (incyc && ctype == CY_INTACK && tst != BT_T1));
  assign read_strobe_n = !((incyc && is_read) || (io_act && ctype == CY_IORD));
  assign write_strobe_n = !(tst == BT_T2 && (ctype inside {CY_MEMWR, CY_IOWR}));
  assign fetch_cycle_strobe_n = !(incyc && cur_m1);
  assign status_line = !(incyc && cur_st_low);
  assign data_oe = (tst inside {BT_T2, BT_T3}) && (ctype inside {CY_MEMWR, CY_IOWR});
  assign bus_oe = (gst != G_ON);
  assign bus_ack_n = (gst != G_ON);

  always_comb begin
    grant_target = RUN_BREQ_CYC;
    if (pmode == P_IDLE) begin
      grant_target = RUN_BREQ_CYC + IDLE_EXTRA_CYC;
    end else if (pmode != P_RUN) begin
      grant_target = recovery_cycles(quick_recovery_select);
    end
  end

  // Bus grant to an external master
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gst <= G_OFF;
      gcnt <= 18'h00000;
    end else begin
      unique case (gst)
        G_OFF: begin
          gcnt <= 18'h00000;
          if (breq && ((pmode == P_RUN && bus_quiet)
              || (pmode != P_RUN && low_power_bus_release_bit))) begin
            gst <= G_WAIT;
          end
        end
        G_WAIT: begin
          if (!breq) begin
            gst <= G_OFF;
          end else if (gcnt >= grant_target - 18'h00001) begin
            gst <= G_ON;
          end else begin
            gcnt <= gcnt + 18'h00001;
          end
        end
        G_ON: begin
          if (!breq) begin
            gst <= G_OFF;
          end
        end
        default: gst <= G_OFF;
      endcase
    end
  end

  // Sleep modes and wake-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pmode <= P_RUN;
      wcnt <= 18'h00000;
      wnmi <= 1'b0;
      wake_service <= 1'b0;
      wake_resume <= 1'b0;
    end else begin
      wake_service <= 1'b0;
      wake_resume <= 1'b0;
      unique case (pmode)
        P_RUN: begin
          if (sleep_req && bus_quiet && gst == G_OFF) begin
            pmode <= sleep_standby ? P_STBY : P_IDLE;
          end
        end
        P_IDLE: begin
          if (gst == G_OFF && (nmi_low || int_pending)) begin
            pmode <= P_RUN;
            wake_service <= nmi_low || interrupt_enable_flag;
            wake_resume <= !(nmi_low || interrupt_enable_flag);
          end
        end
        P_STBY: begin
          wcnt <= 18'h00000;
          if (gst == G_OFF && (nmi_low || int_pending)) begin
            pmode <= P_WAKE;
            wnmi <= nmi_low;
          end
        end
        P_WAKE: begin
          if (!wnmi && !int_pending) begin
            pmode <= P_STBY;
          end else if (wcnt >= recovery_cycles(quick_recovery_select) - 18'h00001) begin
            pmode <= P_RUN;
            wake_service <= wnmi || interrupt_enable_flag;
            wake_resume <= !(wnmi || interrupt_enable_flag);
          end else begin
            wcnt <= wcnt + 18'h00001;
          end
        end
        default: pmode <= P_RUN;
      endcase
    end
  end

  // Clock output stops in low-power modes unless the bus is being granted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      system_clock_output_en <= 1'b1;
    end else begin
      system_clock_output_en <= (pmode == P_RUN) || (gst != G_OFF);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  oneshot_read_a: assert property (
    (io_rd && io_addr == OMC_ADDR) |=> io_rdata[OMC_ONESHOT_BIT])
    else $error("one-shot bit read back as zero");
  fetch_strobe_a: assert property (
    (core_start && cyc_type == CY_OPCODE && fetch_strobe_enable)
    |=> !fetch_cycle_strobe_n [*3] ##1 fetch_cycle_strobe_n)
    else $error("fetch strobe not held for three clocks");
  no_strobe_a: assert property (
    (core_start && cyc_type == CY_OPCODE && !fetch_strobe_enable && !force_pend)
    |=> fetch_cycle_strobe_n [*3])
    else $error("fetch strobe driven while disabled");
  oneshot_force_a: assert property (
    (core_start && cyc_type == CY_OPCODE && force_pend) |=> !fetch_cycle_strobe_n)
    else $error("forced fetch strobe missing");
  oneshot_lapse_a: assert property (
    (core_start && cyc_type == CY_OPCODE && !omc_wr) |=> !force_pend)
    else $error("forced fetch strobe did not lapse");
  refetch_gap_a: assert property (
    $rose(seq == SQ_GAP3) |-> (memory_request_strobe_n && read_strobe_n && !data_oe
    && fetch_cycle_strobe_n && status_line) [*3] ##1 (!fetch_cycle_strobe_n && status_line))
    else $error("refetch gap or strobed refetch wrong");
  return_from_interrupt_once_a: assert property (
    (tst == BT_T3 && ctype == CY_OPCODE && seq == SQ_NONE && fetch_strobe_enable)
    |=> seq == SQ_NONE)
    else $error("refetch started while fetch strobe enabled");
  io_timing_a: assert property (
    (tst == BT_T1 && ctype == CY_IORD) |-> (io_request_strobe_n == !io_timing_compat))
    else $error("I/O strobe timing does not match mode");
  idle_grant_a: assert property (
    (pmode == P_IDLE && gst == G_OFF && breq && low_power_bus_release_bit)
    ##1 breq [*8] |=> bus_ack_n ##1 (!breq || !bus_ack_n))
    else $error("idle bus grant latency wrong");
  clock_stop_a: assert property (
    (pmode == P_IDLE && gst == G_ON && !breq) |=> ##1 (!system_clock_output_en && pmode == P_IDLE))
    else $error("clock output kept running after idle grant");
  standby_stay_a: assert property (
    (pmode == P_WAKE && !wnmi && !int_pending) |=> pmode == P_STBY)
    else $error("standby left although wake line dropped");
  quick_restart_a: assert property (
    (pmode == P_WAKE && quick_recovery_select) |-> wcnt < QUICK_RECOVERY_CYC)
    else $error("quick recovery overran 64 clocks");
  wake_kind_a: assert property (
    (pmode == P_WAKE && $past(pmode) == P_WAKE && quick_recovery_select
    && wcnt == QUICK_RECOVERY_CYC - 18'h00001 && (wnmi || int_pending))
    |=> (pmode == P_RUN && (wake_service != wake_resume)))
    else $error("standby exit did not restart correctly");

  refetch_c: cover property ($rose(seq == SQ_SP1));
  oneshot_c: cover property (core_start && force_pend && !fetch_strobe_enable);
  idle_grant_c: cover property (pmode == P_IDLE && gst == G_ON);
  standby_exit_c: cover property (pmode == P_WAKE ##1 pmode == P_RUN);
endmodule

`default_nettype wire

//--- verification/bcs_far_model.sv
// Far-side model: memory and legacy peripherals answering reads, plus an
// external bus master. Assumes registered address and active-low strobes.
`default_nettype none

module bcs_far_model (
  input wire logic clk,
  input wire logic want_bus,
  input wire logic [19:0] addr_out,
  input wire logic read_strobe_n,
  output logic [7:0] data_in,
  output logic bus_request_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // Return opcode pair at 0x10/0x11, a fixed pattern elsewhere
  function automatic logic [7:0] mem(input logic [19:0] a);
    if (a == 20'h00010)
      return 8'hed;
    if (a == 20'h00011)
      return 8'h4d;
    return a[7:0] ^ 8'h5a;
  endfunction

  // Released bus shows the inverse, never a stale value
  assign data_in = read_strobe_n ? ~mem(addr_out) : mem(addr_out);

  // Master raises and later negates its request
  initial bus_request_n = 1'b1;
  always @(posedge clk) begin
    bus_request_n <= ~want_bus;
  end
endmodule

`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the bus compatibility and low-power block.
// Assumes the far-side model answers reads and plays the external master.
`default_nettype none

module tb;
  import bcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic nrst, io_wr, io_rd, cyc_start, sleep_req, sleep_standby, want_bus;
  logic low_power_bus_release_bit, quick_recovery_select, interrupt_enable_flag, nmi_n;
  logic [7:0] io_addr, io_wdata, cyc_wdata, io_rdata, cyc_rdata, data_in, rd_data, data_out;
  logic [19:0] cyc_addr, stack_pointer, addr_out;
  logic [2:0] ext_int_enable, ext_int_n, fs_v, io_v, st_v, rd_v, wr_v, oe_v;
  logic cyc_ready, cyc_done, data_oe, memory_request_strobe_n, io_request_strobe_n;
  logic read_strobe_n, fetch_cycle_strobe_n, status_line, bus_request_n, bus_ack_n;
  logic system_clock_output_en, wake_service, wake_resume, write_strobe_n, bus_oe;
  logic [4:0] strb;
  bcs_cyc_t cyc_type;
  int num_errors = 0;
  int total_checks = 0;

  assign strb = {fetch_cycle_strobe_n, memory_request_strobe_n, read_strobe_n,
                 status_line, io_request_strobe_n};

  always #12.5 clk = ~clk;

  bcs_ctrl #(.SLOW_RECOVERY_CYC(200)) i_bcs_ctrl (
    .clk(clk), .nrst(nrst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .cyc_start(cyc_start),
    .cyc_type(cyc_type), .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata),
    .stack_pointer(stack_pointer), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
    .cyc_rdata(cyc_rdata), .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .bus_oe(bus_oe), .memory_request_strobe_n(memory_request_strobe_n),
    .io_request_strobe_n(io_request_strobe_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .fetch_cycle_strobe_n(fetch_cycle_strobe_n),
    .status_line(status_line), .sleep_req(sleep_req), .sleep_standby(sleep_standby),
    .low_power_bus_release_bit(low_power_bus_release_bit),
    .quick_recovery_select(quick_recovery_select),
    .interrupt_enable_flag(interrupt_enable_flag), .ext_int_enable(ext_int_enable),
    .nmi_n(nmi_n), .ext_int_n(ext_int_n), .bus_request_n(bus_request_n),
    .bus_ack_n(bus_ack_n), .system_clock_output_en(system_clock_output_en),
    .wake_service(wake_service), .wake_resume(wake_resume)
  );

  bcs_far_model i_bcs_far_model (
    .clk(clk), .want_bus(want_bus), .addr_out(addr_out),
    .read_strobe_n(read_strobe_n), .data_in(data_in), .bus_request_n(bus_request_n)
  );

  task automatic test_done();
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Event 0 grant, 1 grant gone, 2 wake pulse, 3 bus ready
  task automatic cnt(input int sel, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 && bus_ack_n === 1'b0) || (sel == 1 && bus_ack_n === 1'b1) ||
          (sel == 2 && (wake_service === 1'b1 || wake_resume === 1'b1)) ||
          (sel == 3 && cyc_ready === 1'b1))
        break;
    end
  endtask

  task automatic need(input int sel, input int lim, output int n);
    cnt(sel, lim, n);
    if (n == lim) begin
      num_errors++;
      $display("[ERR] wait %0d expected event seen timeout", sel);
      test_done();
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    v = io_rdata;
  endtask

  // One bus cycle; strobes of T1..T3 land in bits 0..2
  task automatic bus_cyc(input bcs_cyc_t t, input logic [19:0] a);
    int n;
    need(3, 40, n);
    @(posedge clk);
    cyc_start <= 1'b1;
    cyc_type <= t;
    cyc_addr <= a;
    cyc_wdata <= ~a[7:0];
    @(posedge clk);
    cyc_start <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      #1;
      fs_v[i] = fetch_cycle_strobe_n;
      io_v[i] = io_request_strobe_n;
      st_v[i] = status_line;
      rd_v[i] = read_strobe_n;
      wr_v[i] = write_strobe_n;
      oe_v[i] = data_oe;
      @(posedge clk);
    end
    #1;
    chk("cycle done", 1, cyc_done);
    rd_data = cyc_rdata;
  endtask

  task automatic enter_sleep(input logic sb, input logic q);
    @(posedge clk);
    sleep_standby <= sb;
    quick_recovery_select <= q;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [7:0] v;
    rd_reg(8'h3e, v);
    chk("mode reset", 8'he0, v);
    wr_reg(8'h3f, 8'h00);
    rd_reg(8'h3e, v);
    chk("unmapped write", 8'he0, v);
  endtask

  task automatic t_types();
    for (int k = 0; k < 7; k++) begin
      bus_cyc(bcs_cyc_t'(k), 20'h00020);
      chk("fetch strobe", (k < 3) ? 3'h0 : 3'h7, fs_v);
      chk("status", (k == 0) ? 3'h0 : 3'h7, st_v);
      chk("io strobe", (k == 1) ? 3'h1 : (k > 4) ? 3'h0 : 3'h7, io_v);
      chk("write strobe", (k == 4 || k == 6) ? 3'h5 : 3'h7, wr_v);
      chk("data drive", (k == 4 || k == 6) ? 3'h6 : 3'h0, oe_v);
      if (k == 3)
        chk("read data", 8'h7a, rd_data);
      if (k == 4)
        chk("write data", 8'hdf, data_out);
    end
  endtask

  task automatic t_iotime();
    bus_cyc(CY_IORD, 20'h00055);
    chk("io strobe compat", 3'h0, io_v);
    chk("read compat", 3'h0, rd_v);
    wr_reg(8'h3e, 8'hc0);
    bus_cyc(CY_IORD, 20'h00055);
    chk("io strobe legacy", 3'h1, io_v);
    chk("read legacy", 3'h1, rd_v);
    wr_reg(8'h3e, 8'he0);
  endtask

  task automatic t_oneshot();
    logic [7:0] v;
    wr_reg(8'h3e, 8'h60);
    rd_reg(8'h3e, v);
    chk("mode readback", 8'h60, v);
    bus_cyc(CY_OPCODE, 20'h00030);
    chk("fetch off", 3'h7, fs_v);
    wr_reg(8'h3e, 8'h20);
    rd_reg(8'h3e, v);
    chk("oneshot reads one", 8'h60, v);
    bus_cyc(CY_MEMRD, 20'h00030);
    chk("no force on data read", 3'h7, fs_v);
    bus_cyc(CY_OPCODE, 20'h00031);
    chk("forced strobe", 3'h0, fs_v);
    bus_cyc(CY_OPCODE, 20'h00032);
    chk("force lapsed", 3'h7, fs_v);
    wr_reg(8'h3e, 8'h60);
    bus_cyc(CY_OPCODE, 20'h00033);
    chk("write one no force", 3'h7, fs_v);
  endtask

  task automatic t_return_from_interrupt(input logic en);
    logic [19:0] ea;
    int n;
    wr_reg(8'h3e, {en, 7'h60});
    bus_cyc(CY_OPCODE, 20'h00010);
    chk("first opcode", 8'hed, rd_data);
    bus_cyc(CY_OPCODE, 20'h00011);
    chk("opcode status", 3'h0, st_v);
    if (en) begin
      chk("single fetch", 1, cyc_ready);
      chk("no refetch", 5'h1f, strb);
    end else begin
      for (int k = 0; k < 16; k++) begin
        ea = (k < 6) ? 20'h00010 : (k < 10) ? 20'h00011 : (k < 13) ? 20'h00100 : 20'h00101;
        chk("refetch strobes", (k < 3 || k == 6) ? 5'h1f : (k < 6) ? 5'h03 : 5'h13, strb);
        chk("refetch data idle", 0, data_oe);
        if (k > 2 && k != 6)
          chk("refetch address", ea, addr_out);
        @(posedge clk);
        #1;
      end
      need(3, 4, n);
    end
  endtask

  task automatic t_idle();
    int nr, ni, n;
    @(posedge clk);
    want_bus <= 1'b1;
    need(0, 50, nr);
    chk("bus floated", 0, bus_oe);
    @(posedge clk);
    want_bus <= 1'b0;
    need(1, 20, n);
    enter_sleep(1'b0, 1'b1);
    low_power_bus_release_bit <= 1'b0;
    want_bus <= 1'b1;
    cnt(0, 30, n);
    chk("no grant without release", 30, n);
    @(posedge clk);
    want_bus <= 1'b0;
    repeat (5) @(posedge clk);
    low_power_bus_release_bit <= 1'b1;
    @(posedge clk);
    want_bus <= 1'b1;
    need(0, 60, ni);
    chk("idle grant delay", nr + 8, ni);
    chk("idle bus floated", 0, bus_oe);
    @(posedge clk);
    want_bus <= 1'b0;
    need(1, 20, n);
    repeat (4) @(posedge clk);
    #1;
    chk("clock stopped", 0, system_clock_output_en);
    chk("still idle", 0, cyc_ready);
    @(posedge clk);
    ext_int_n <= 3'h6;
    need(2, 20, n);
    chk("idle wake", 2'h2, {wake_service, wake_resume});
    @(posedge clk);
    ext_int_n <= 3'h7;
    need(3, 20, n);
  endtask

  task automatic t_wake(input logic q, input logic f, input int lo, input logic [1:0] ex);
    int n;
    enter_sleep(1'b1, q);
    @(posedge clk);
    interrupt_enable_flag <= f;
    ext_int_n <= 3'h6;
    need(2, lo + 40, n);
    chk("wake kind", ex, {wake_service, wake_resume});
    chk("restart delay", 1, n >= lo && n <= lo + 8);
    @(posedge clk);
    ext_int_n <= 3'h7;
    interrupt_enable_flag <= 1'b1;
  endtask

  task automatic t_stby_misc();
    int n;
    enter_sleep(1'b1, 1'b1);
    @(posedge clk);
    ext_int_n <= 3'h6;
    repeat (20) @(posedge clk);
    ext_int_n <= 3'h7;
    cnt(2, 150, n);
    chk("early drop stays", 150, n);
    @(posedge clk);
    want_bus <= 1'b1;
    need(0, 100, n);
    chk("standby grant delay", 1, n >= 64 && n <= 72);
    @(posedge clk);
    want_bus <= 1'b0;
    need(1, 20, n);
    @(posedge clk);
    interrupt_enable_flag <= 1'b0;
    nmi_n <= 1'b0;
    need(2, 100, n);
    chk("nmi wake", 2'h2, {wake_service, wake_resume});
    @(posedge clk);
    nmi_n <= 1'b1;
    interrupt_enable_flag <= 1'b1;
  endtask

  initial begin
    {nrst, io_wr, io_rd, cyc_start, sleep_req, sleep_standby, quick_recovery_select} = 7'h00;
    {want_bus, low_power_bus_release_bit, interrupt_enable_flag, nmi_n} = 4'h7;
    {io_addr, io_wdata, cyc_wdata} = 24'h000000;
    cyc_addr = 20'h00000;
    stack_pointer = 20'h00100;
    ext_int_enable = 3'h1;
    ext_int_n = 3'h7;
    cyc_type = CY_OPCODE;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_types();
    t_iotime();
    t_oneshot();
    t_return_from_interrupt(1'b1);
    t_return_from_interrupt(1'b0);
    t_idle();
    t_wake(1'b1, 1'b1, 64, 2'h2);
    t_wake(1'b1, 1'b0, 64, 2'h1);
    t_wake(1'b0, 1'b1, 200, 2'h2);
    t_stby_misc();
    test_done();
  end
endmodule

`default_nettype wire
